// [logic/pmcd_pkg.sv]
// Purpose: Shared constants and carriers for the power module command decoder.
// Assumes: Command codes are one byte; scaled values travel as raw direct-format integers.
// Notes:   Register indices follow the order of the writable code table below.
package pmcd_pkg;

  // Command codes.
  localparam logic [7:0] CMD_RUN = 8'h01, CMD_ENSRC = 8'h02, CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_SAVE = 8'h11, CMD_RESTORE = 8'h12, CMD_FMT = 8'h20;
  localparam logic [7:0] CMD_SETPT = 8'h21, CMD_TRIM = 8'h22, CMD_MAX = 8'h24;
  localparam logic [7:0] CMD_MHI = 8'h25, CMD_MLO = 8'h26, CMD_SLEW = 8'h27;
  localparam logic [7:0] CMD_FBDIV = 8'h29, CMD_SENSE = 8'h2a, CMD_VON = 8'h35;
  localparam logic [7:0] CMD_VOFF = 8'h36, CMD_OV = 8'h40, CMD_UV = 8'h44;
  localparam logic [7:0] CMD_OC = 8'h46, CMD_OTF = 8'h4f, CMD_OTW = 8'h51;
  localparam logic [7:0] CMD_UTW = 8'h52, CMD_UTF = 8'h53, CMD_VINOV = 8'h55;
  localparam logic [7:0] CMD_TOND = 8'h60, CMD_RISE = 8'h61, CMD_TOFFD = 8'h64;
  localparam logic [7:0] CMD_SUMB = 8'h78, CMD_SUMW = 8'h79, CMD_STVO = 8'h7a;
  localparam logic [7:0] CMD_STIO = 8'h7b, CMD_STIN = 8'h7c, CMD_STTE = 8'h7d;
  localparam logic [7:0] CMD_STCL = 8'h7e, CMD_RDVIN = 8'h88, CMD_RDVO = 8'h8b;
  localparam logic [7:0] CMD_RDIO = 8'h8c, CMD_RDTE = 8'h8d, CMD_KEY = 8'hea;
  localparam logic [7:0] CMD_LEVEL = 8'heb;

  // Writable storage: element i of the table holds the code of register i.
  localparam int NUM_REGS = 24;
  localparam logic [NUM_REGS-1:0][7:0] RW_CODES = {
    CMD_KEY, CMD_LEVEL, CMD_TOFFD, CMD_RISE, CMD_TOND, CMD_VINOV, CMD_UTF, CMD_UTW,
    CMD_OTW, CMD_OTF, CMD_OC, CMD_UV, CMD_OV, CMD_VOFF, CMD_VON, CMD_FBDIV,
    CMD_SLEW, CMD_MLO, CMD_MHI, CMD_MAX, CMD_TRIM, CMD_SETPT, CMD_ENSRC, CMD_RUN};
  localparam logic [4:0] IX_RUN = 5'h00, IX_ENSRC = 5'h01, IX_SETPT = 5'h02;
  localparam logic [4:0] IX_MHI = 5'h05, IX_MLO = 5'h06, IX_OV = 5'h0b, IX_UV = 5'h0c;
  localparam logic [4:0] IX_LEVEL = 5'h16, IX_KEY = 5'h17;

  // Direct-format slopes, times 100 so the fractional ones stay exact.
  localparam int SLOPE_VOUT_X100 = 512000, SLOPE_SLEW_X100 = 25600;
  localparam int SLOPE_DIV_X100 = 1638400, SLOPE_VIN_X100 = 186200;
  localparam int SLOPE_IOUT_X100 = 1024, SLOPE_TEMP_X100 = 100;
  localparam int SLOPE_DELAY_X100 = 6256, SLOPE_RISE_X100 = 3200, SLOPE_RDVO_X100 = 64000;

  // Trim-derived limits in percent of the setpoint.
  localparam logic [7:0] PCT_HI = 8'h69, PCT_LO = 8'h5f, PCT_OV = 8'h78, PCT_UV = 8'h50;
  localparam logic [23:0] PCT_FULL = 24'h000064;

  // Target address range selected by the strap.
  localparam logic [6:0] ADDR_BASE = 7'h10, ADDR_LAST = 7'h27;
  localparam logic [4:0] SEL_MAX = 5'h17;

  // Communication flag bits and reset values.
  localparam int CML_BAD_CMD = 7, CML_BAD_DATA = 6, SUM_CML_BIT = 1;
  localparam logic [7:0] CML_RESET = 8'h00, RD_FILL = 8'hff;
  localparam logic [1:0] WARM_DONE = 2'h3;

  typedef logic [NUM_REGS-1:0][15:0] pmcd_regs_t;

  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_CMD, PH_WR, PH_RD, PH_SKIP} pmcd_phase_t;

  typedef struct packed {
    logic       ok;
    logic       rd;
    logic       wr;
    logic [1:0] nbytes;
    logic [4:0] idx;
  } pmcd_cmd_info_t;

  typedef struct packed {
    logic [7:0]  byte_sum;
    logic [15:0] word_sum;
    logic [7:0]  vout;
    logic [7:0]  iout;
    logic [7:0]  inp;
    logic [7:0]  temp;
  } pmcd_status_t;

  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] vout;
    logic [15:0] iout;
    logic [15:0] temp;
  } pmcd_telem_t;

endpackage : pmcd_pkg

// [logic/pmcd_top.sv]
// Purpose: Command decoder of a point-of-load converter on the two-wire management bus.
// Assumes: Bus clock up to 400 kHz against a 10 MHz system clock; no clock stretching.
// Notes:   Bits are caught on the bus clock itself, framing runs on the system clock.
// How it works
// - Code 01 is a one-byte read/write run-state control register.
// - Code 02 is a one-byte read/write enable source configuration register.
// - Code 11 takes no data and asks persistent memory to save settings.
// - Code 12 takes no data and reloads all settings except the key (EA) from stored defaults.
// - Code 03 takes no data and clears the latched fault indications.
// - Code 20 reads a fixed one-byte output format descriptor; writes leave it unchanged and set the bad-data flag.
// - Codes 21,22,24,25,26 are two-byte read/write output voltage registers, slope 5120.
// - Code 27 is a two-byte read/write slew-rate register, slope 256.
// - Code 29 is read/write feedback ratio, code 2A read-only sense ratio.
// - Codes 35 and 36 are two-byte read/write input thresholds, slope 1862.
// - Codes 40 and 44 are two-byte output over/undervoltage limits, slope 5120.
// - Code 46 is a two-byte read/write overcurrent limit, slope 10.24.
// - Codes 4F,51,52,53 are two-byte temperature limits with unit slope.
// - Code 55 is a two-byte read/write input overvoltage limit, slope 1862.
// - Codes 60 and 64 are two-byte start and stop delays, slope 62.56.
// - Code 61 is a two-byte read/write ramp-up time, slope 32.
// - Codes 78 and 79 return one- and two-byte summary status, read-only.
// - Codes 7A to 7E return one-byte detailed status, read-only.
// - Codes 88,8B,8C,8D return two-byte telemetry readings, read-only.
// - Code EA takes a write-only two-byte key, EB a read/write protection level.
// - Target address comes from the address strap, 10h to 27h in steps of one.
// - A trim setpoint sets margins 105/95 percent and limits 120/80 percent.
`timescale 1ns/1ps
module pmcd_top
  import pmcd_pkg::*;
#(
  parameter logic [7:0]  FMT_DESC    = 8'h40,
  parameter logic [15:0] SENSE_RATIO = 16'h4000
) (
  // System clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Management bus pins; the bus clock is never driven
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  // Address strap, resistor code 0 to 23
  input  wire logic [4:0]   addr_sel,
  // Converter side
  input  wire pmcd_status_t status_in,
  input  wire pmcd_telem_t  telem_in,
  input  wire pmcd_regs_t   stored_defaults,
  input  wire logic         trim_load,
  input  wire logic [15:0]  trim_setpoint,
  output pmcd_regs_t        settings,
  output logic [6:0]        own_addr,
  output logic [7:0]        comm_flags,
  output logic              save_req,
  output logic              restore_req,
  output logic              clear_faults
);

  typedef struct packed {
    logic [2:0]      scl_p;
    logic [2:0]      sda_p;
    logic            scl_f;
    logic            sda_f;
    logic [2:0][4:0] sel_p;
    logic [1:0]      warm;
    logic [6:0]      addr;
    pmcd_phase_t     ph;
    logic [3:0]      bits;
    logic [7:0]      rx;
    logic [7:0]      tx;
    logic            ack;
    logic [1:0]      nbyte;
    logic [7:0]      cmd;
    logic [15:0]     wbuf;
    logic            oe;
    logic [7:0]      cml;
    pmcd_regs_t      regs;
    logic            save;
    logic            restore;
    logic            clear;
    logic            commit;
  } pmcd_state_t;

  pmcd_state_t    q;
  pmcd_state_t    next_q;
  logic [1:0]     rst_sync;
  logic           rst_n;
  logic           bit_cap;
  logic           rise;
  logic           fall;
  logic           start;
  logic           stop;
  logic [7:0]     rbyte;
  logic [15:0]    rword;
  pmcd_cmd_info_t info;
  pmcd_cmd_info_t new_info;

  function automatic pmcd_cmd_info_t cmd_lookup(input logic [7:0] c);
    pmcd_cmd_info_t r;
    r = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (RW_CODES[i] == c) begin
        r.ok     = 1'b1;
        r.rd     = (5'(i) != IX_KEY);
        r.wr     = 1'b1;
        r.nbytes = (5'(i) == IX_RUN || 5'(i) == IX_ENSRC || 5'(i) == IX_LEVEL) ? 2'h1 : 2'h2;
        r.idx    = 5'(i);
      end
    end
    case (c)
      CMD_CLEAR, CMD_SAVE, CMD_RESTORE: begin
        r.ok = 1'b1;
        r.wr = 1'b1;
      end
      CMD_FMT, CMD_SUMB, CMD_STVO, CMD_STIO, CMD_STIN, CMD_STTE, CMD_STCL: begin
        r.ok     = 1'b1;
        r.rd     = 1'b1;
        r.nbytes = 2'h1;
      end
      CMD_SENSE, CMD_SUMW, CMD_RDVIN, CMD_RDVO, CMD_RDIO, CMD_RDTE: begin
        r.ok     = 1'b1;
        r.rd     = 1'b1;
        r.nbytes = 2'h2;
      end
      default: begin
      end
    endcase
    return r;
  endfunction : cmd_lookup

  function automatic logic [15:0] pct(input logic [15:0] v, input logic [7:0] p);
    logic [23:0] prod;
    prod = 24'(v) * 24'(p);
    return 16'(prod / PCT_FULL);
  endfunction : pct

  // Reset is released through two flops so every state flop leaves reset together.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // The data bit is caught on the real bus clock edge and stays put for the
  // whole high and low phase, so the system clock side may read it after its
  // own synchronised view of the rising edge.
  always_ff @(posedge scl_in or negedge rst_n) begin
    if (!rst_n) begin
      bit_cap <= 1'b0;
    end else begin
      bit_cap <= sda_in;
    end
  end

  // Read data for the command in hand; the format and sense ratio are fixed here.
  always_comb begin
    info  = cmd_lookup(q.cmd);
    new_info = cmd_lookup({q.rx[6:0], bit_cap});
    rword = {RD_FILL, RD_FILL};
    if (info.ok && info.rd && info.idx != IX_KEY && RW_CODES[info.idx] == q.cmd) begin
      rword = q.regs[info.idx];
    end
    case (q.cmd)
      CMD_FMT:   rword = {8'h00, FMT_DESC};
      CMD_SENSE: rword = SENSE_RATIO;
      CMD_SUMB:  rword = {8'h00, status_in.byte_sum | {6'h00, |q.cml, 1'b0}};
      CMD_SUMW:  rword = status_in.word_sum | {14'h0000, |q.cml, 1'b0};
      CMD_STVO:  rword = {8'h00, status_in.vout};
      CMD_STIO:  rword = {8'h00, status_in.iout};
      CMD_STIN:  rword = {8'h00, status_in.inp};
      CMD_STTE:  rword = {8'h00, status_in.temp};
      CMD_STCL:  rword = {8'h00, q.cml};
      CMD_RDVIN: rword = telem_in.vin;
      CMD_RDVO:  rword = telem_in.vout;
      CMD_RDIO:  rword = telem_in.iout;
      CMD_RDTE:  rword = telem_in.temp;
      default: begin
      end
    endcase
    // Low byte goes out first; anything past the register's width reads as fill.
    case (q.nbyte)
      2'h0:    rbyte = rword[7:0];
      2'h1:    rbyte = (info.nbytes == 2'h2) ? rword[15:8] : RD_FILL;
      default: rbyte = RD_FILL;
    endcase
  end

  always_comb begin
    next_q         = q;
    next_q.save    = 1'b0;
    next_q.restore = 1'b0;
    next_q.clear   = 1'b0;
    next_q.commit  = 1'b0;
    next_q.scl_p   = {q.scl_p[1:0], scl_in};
    next_q.sda_p   = {q.sda_p[1:0], sda_in};
    next_q.sel_p   = {q.sel_p[1:0], addr_sel};
    if (q.scl_p[1] == q.scl_p[2]) begin
      next_q.scl_f = q.scl_p[2];
    end
    if (q.sda_p[1] == q.sda_p[2]) begin
      next_q.sda_f = q.sda_p[2];
    end
    rise  = !q.scl_f && next_q.scl_f;
    fall  = q.scl_f && !next_q.scl_f;
    start = q.scl_f && next_q.scl_f && q.sda_f && !next_q.sda_f;
    stop  = q.scl_f && next_q.scl_f && !q.sda_f && next_q.sda_f;

    // The strap is taken once, after the synchroniser has filled and settled.
    if (q.warm != WARM_DONE) begin
      if (q.warm != 2'h2) begin
        next_q.warm = q.warm + 2'h1;
      end else if (q.sel_p[1] == q.sel_p[2]) begin
        next_q.warm = WARM_DONE;
        next_q.addr = ADDR_BASE + 7'((q.sel_p[2] > SEL_MAX) ? SEL_MAX : q.sel_p[2]);
        for (int i = 0; i < NUM_REGS - 1; i++) begin
          next_q.regs[i] = stored_defaults[i];
        end
      end
    end else if (start) begin
      next_q.ph    = PH_ADDR;
      next_q.bits  = 4'h0;
      next_q.oe    = 1'b0;
      next_q.nbyte = 2'h0;
    end else if (stop) begin
      next_q.ph = PH_IDLE;
      next_q.oe = 1'b0;
      if (q.ph == PH_WR) begin
        if (!info.wr || q.nbyte != info.nbytes) begin
          next_q.cml[CML_BAD_DATA] = 1'b1;
        end else begin
          next_q.commit = 1'b1;
          case (q.cmd)
            CMD_CLEAR: begin
              next_q.clear = 1'b1;
              next_q.cml   = CML_RESET;
            end
            CMD_SAVE: begin
              // Each save wears the memory and needs power held afterwards; the host
              // paces these, so no count or lock-out is kept here.
              next_q.save = 1'b1;
            end
            CMD_RESTORE: begin
              next_q.restore = 1'b1;
              for (int i = 0; i < NUM_REGS - 1; i++) begin
                next_q.regs[i] = stored_defaults[i];
              end
            end
            default: begin
              // Values are stored raw, exactly as the host scaled them.
              if (info.nbytes == 2'h1) begin
                next_q.regs[info.idx] = {8'h00, q.wbuf[7:0]};
              end else begin
                next_q.regs[info.idx] = q.wbuf;
              end
            end
          endcase
        end
      end
    end else if (q.ph != PH_IDLE && q.ph != PH_SKIP) begin
      if (rise) begin
        if (q.bits == 4'h8) begin
          next_q.bits = 4'h0;
          if (q.ph == PH_RD) begin
            next_q.ack = 1'b0;
            if (q.ack) begin
              // Address ack slot: the low byte was already loaded when the address matched.
            end else if (bit_cap) begin
              next_q.ph = PH_SKIP;
            end else begin
              next_q.tx    = rbyte;
              next_q.nbyte = (q.nbyte == 2'h3) ? q.nbyte : q.nbyte + 2'h1;
            end
          end
        end else begin
          next_q.rx   = {q.rx[6:0], bit_cap};
          next_q.bits = q.bits + 4'h1;
          if (q.bits == 4'h7) begin
            case (q.ph)
              PH_ADDR: begin
                next_q.ack = (q.rx[6:0] == q.addr);
                if (q.rx[6:0] != q.addr) begin
                  next_q.ph = PH_SKIP;
                end else if (bit_cap) begin
                  next_q.ph    = PH_RD;
                  next_q.tx    = rbyte;
                  next_q.nbyte = 2'h1;
                  if (!info.ok || !info.rd) begin
                    next_q.cml[CML_BAD_DATA] = 1'b1;
                  end
                end else begin
                  next_q.ph = PH_CMD;
                end
              end
              PH_CMD: begin
                next_q.cmd = {q.rx[6:0], bit_cap};
                next_q.ack = new_info.ok;
                if (!new_info.ok) begin
                  next_q.ph               = PH_SKIP;
                  next_q.cml[CML_BAD_CMD] = 1'b1;
                end else begin
                  next_q.ph = PH_WR;
                end
              end
              PH_WR: begin
                next_q.ack = 1'b1;
                if (q.nbyte == 2'h0) begin
                  next_q.wbuf[7:0] = {q.rx[6:0], bit_cap};
                end else if (q.nbyte == 2'h1) begin
                  next_q.wbuf[15:8] = {q.rx[6:0], bit_cap};
                end
                next_q.nbyte = (q.nbyte == 2'h3) ? q.nbyte : q.nbyte + 2'h1;
              end
              default: begin
              end
            endcase
          end
        end
      end else if (fall) begin
        if (q.bits == 4'h8) begin
          next_q.oe = q.ack;
        end else if (q.ph == PH_RD) begin
          next_q.oe = !q.tx[3'(4'h7 - q.bits)];
        end else begin
          next_q.oe = 1'b0;
        end
      end
    end

    // A trimmed setpoint carries its margins and limits along.
    if (trim_load && q.warm == WARM_DONE) begin
      next_q.regs[IX_SETPT] = trim_setpoint;
      next_q.regs[IX_MHI]   = pct(trim_setpoint, PCT_HI);
      next_q.regs[IX_MLO]   = pct(trim_setpoint, PCT_LO);
      next_q.regs[IX_OV]    = pct(trim_setpoint, PCT_OV);
      next_q.regs[IX_UV]    = pct(trim_setpoint, PCT_UV);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q       <= '0;
      q.scl_p <= 3'h7;
      q.sda_p <= 3'h7;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.addr  <= ADDR_BASE;
      q.ph    <= PH_IDLE;
      q.cml   <= CML_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign sda_out      = 1'b0;
  assign sda_oe       = q.oe;
  assign settings     = q.regs;
  assign own_addr     = q.addr;
  assign comm_flags   = q.cml;
  assign save_req     = q.save;
  assign restore_req  = q.restore;
  assign clear_faults = q.clear;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_trim_req;
    trim_load && q.warm == WARM_DONE;
  endsequence
  sequence s_bad_count;
    stop && q.ph == PH_WR && q.nbyte != info.nbytes;
  endsequence

  a_addr_range: assert property (own_addr >= ADDR_BASE && own_addr <= ADDR_LAST)
    else $error("Target address outside the strap range.");
  a_trim_margins: assert property (s_trim_req |=> settings[IX_MHI] ==
    pct($past(trim_setpoint), PCT_HI) && settings[IX_UV] == pct($past(trim_setpoint), PCT_UV))
    else $error("Trim did not set margins and limits.");
  a_save_cause: assert property (save_req |-> q.cmd == CMD_SAVE && $past(q.nbyte) == 2'h0)
    else $error("Save request without a zero-byte save command.");
  a_restore_copy: assert property (restore_req |->
    settings[IX_SETPT] == $past(stored_defaults[IX_SETPT]) && q.cmd == CMD_RESTORE)
    else $error("Restore did not reload the stored defaults.");
  a_clear_flags: assert property (clear_faults |-> comm_flags == CML_RESET ##1 !clear_faults)
    else $error("Fault clear did not clear the flags in one pulse.");
  a_ro_untouched: assert property (q.commit |-> q.cmd != CMD_FMT && q.cmd != CMD_SENSE)
    else $error("A read-only code was committed.");
  a_bad_count: assert property (s_bad_count |=> comm_flags[CML_BAD_DATA] && !q.commit)
    else $error("Wrong byte count not flagged or was committed.");
  a_word_lsb: assert property (q.commit && q.cmd == CMD_SETPT |->
    settings[IX_SETPT] == $past(q.wbuf))
    else $error("Setpoint write did not store the low-first word.");
  a_run_byte: assert property (q.commit && q.cmd == CMD_RUN |->
    settings[IX_RUN] == {8'h00, $past(q.wbuf[7:0])})
    else $error("Run control write did not store one byte.");
  a_flag_sticky: assert property ($fell(comm_flags[CML_BAD_CMD]) |-> clear_faults)
    else $error("Command error flag dropped without a fault clear.");

endmodule : pmcd_top

// [tb/pmcd_host_model.sv]
// Purpose: Host model for the management bus: start, stop, byte and word transfers.
// Assumes: The tb pulls the data wire up; the bus clock idles high between frames.
// Notes:   Data moves mid-low so the target's hold time is always met.
`timescale 1ns/1ps
module pmcd_host_model (
  // Bus wires
  output logic      scl,
  output logic      host_oe,
  input  wire logic sda
);
  // A 2100 ns bit, faster than the 400 kHz link figure; the target samples the bus on its 100 ns clock.
  localparam int T_Q = 700;

  initial begin
    scl = 1'b1;
    host_oe = 1'b0;
  end

  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    #T_Q;
    host_oe = ~b;
    #T_Q;
    scl = 1'b1;
    r = sda;
    #T_Q;
  endtask : bit_io

  // Repeated start when mid is low, stop when mid is high.
  task automatic cond(input logic mid);
    scl = 1'b0;
    #T_Q;
    host_oe = mid;
    #T_Q;
    scl = 1'b1;
    #T_Q;
    host_oe = ~mid;
    #T_Q;
  endtask : cond

  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q,
                         output logic r);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, r);
  endtask : byte_io

  task automatic xfer(input logic [6:0] adr, input logic [7:0] cmd, input int nw,
                      input logic [23:0] wd, input int nr, output logic [15:0] rd,
                      output logic ok);
    logic [7:0] q;
    logic       r;
    rd = 16'hffff;
    #T_Q;
    host_oe = 1'b1;
    #T_Q;
    byte_io({adr, 1'b0}, 1'b1, q, r);
    ok = ~r;
    byte_io(cmd, 1'b1, q, r);
    ok = ok & ~r;
    for (int i = 0; i < nw; i++) byte_io(wd[8*i+:8], 1'b1, q, r);
    if (nr > 0 && ok) begin
      cond(1'b0);
      byte_io({adr, 1'b1}, 1'b1, q, r);
      for (int i = 0; i < nr; i++) begin
        byte_io(8'hff, i == nr - 1, q, r);
        rd[8*i+:8] = q;
      end
    end
    cond(1'b1);
  endtask : xfer
endmodule : pmcd_host_model

// [tb/tb.sv]
// Purpose: Self-checking bench for the command decoder through its bus pins.
// Assumes: Strap code 5 selects target address 15h.
// Notes:   Expected values come from the code table and the inputs set here.
`timescale 1ns/1ps
module tb;
  import pmcd_pkg::*;
  localparam logic [6:0] DEV = 7'h15;
  logic         clk, rstn, trim_load, sda_oe, sda_out, scl, host_oe, ok;
  logic         save_req, restore_req, clear_faults;
  logic [4:0]   addr_sel;
  logic [6:0]   own_addr;
  logic [7:0]   comm_flags;
  logic [15:0]  trim_setpoint, rd;
  pmcd_status_t status_in;
  pmcd_telem_t  telem_in;
  pmcd_regs_t   stored_defaults, settings;
  logic [7:0]   rc [13];
  logic [15:0]  re [13];
  int           bx [3] = '{0, 1, 22};
  int           miscompares, check_count, n_save, n_rest, n_clr, n0;
  wire          sda = ~(host_oe | sda_oe);

  pmcd_top #(.FMT_DESC(8'h5d), .SENSE_RATIO(16'h2c33)) i_pmcd_top (.clk(clk), .rstn(rstn),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
    .status_in(status_in), .telem_in(telem_in), .stored_defaults(stored_defaults),
    .trim_load(trim_load), .trim_setpoint(trim_setpoint), .settings(settings),
    .own_addr(own_addr), .comm_flags(comm_flags), .save_req(save_req),
    .restore_req(restore_req), .clear_faults(clear_faults));
  pmcd_host_model i_pmcd_host_model (.scl(scl), .host_oe(host_oe), .sda(sda));

  always #50 clk = ~clk;

  always @(posedge clk) begin
    n_save += int'(save_req === 1'b1);
    n_rest += int'(restore_req === 1'b1);
    n_clr += int'(clear_faults === 1'b1);
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] cmd, input int n, input logic [23:0] d);
    i_pmcd_host_model.xfer(DEV, cmd, n, d, 0, rd, ok);
  endtask : wr

  task automatic rdr(input logic [7:0] cmd, input int n);
    i_pmcd_host_model.xfer(DEV, cmd, 0, 24'h000000, n, rd, ok);
  endtask : rdr

  task automatic end_of_test();
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    #9000000;
    miscompares++;
    end_of_test();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    trim_load = 1'b0;
    trim_setpoint = 16'h0000;
    addr_sel = 5'h05;
    status_in = '{8'h84, 16'h1c40, 8'h20, 8'h80, 8'h10, 8'h40};
    telem_in = '{16'h3a2b, 16'h0c80, 16'h0155, 16'h0019};
    for (int i = 0; i < NUM_REGS; i++) stored_defaults[i] = 16'(i * 16'h0111);
    rc = '{CMD_FMT, CMD_SENSE, CMD_SUMB, CMD_SUMW, CMD_STVO, CMD_STIO, CMD_STIN, CMD_STTE,
           CMD_STCL, CMD_RDVIN, CMD_RDVO, CMD_RDIO, CMD_RDTE};
    re = '{16'hff5d, 16'h2c33, 16'hff84, 16'h1c40, 16'hff20, 16'hff80, 16'hff10, 16'hff40,
           16'hff00, 16'h3a2b, 16'h0c80, 16'h0155, 16'h0019};
    repeat (16) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (12) @(posedge clk);
    chk("own_addr", 16'h0015, {9'h000, own_addr});
    chk("sda_out", 16'h0000, {15'h0000, sda_out});
    for (int i = 2; i < 22; i++) chk("loaded", stored_defaults[i], settings[i]);
    for (int i = 2; i < 22; i++) begin
      wr(RW_CODES[i], 2, 24'(16'ha501 + 16'(i)));
      chk("ack", 16'h0001, {15'h0000, ok});
      chk("word reg", 16'ha501 + 16'(i), settings[i]);
      rdr(RW_CODES[i], 2);
      chk("word read", 16'ha501 + 16'(i), rd);
    end
    for (int k = 0; k < 3; k++) begin
      wr(RW_CODES[bx[k]], 1, 24'h00003c + 24'(k));
      rdr(RW_CODES[bx[k]], 1);
      chk("byte reg", 16'h003c + 16'(k), settings[bx[k]]);
      chk("byte read", 16'hff3c + 16'(k), rd);
    end
    for (int k = 0; k < 13; k++) begin
      rdr(rc[k], (re[k][15:8] == 8'hff) ? 1 : 2);
      chk("ro read", re[k], rd);
    end
    // Every refused transfer to this target must leave storage alone and raise exactly one flag.
    wr(CMD_RUN, 2, 24'h000077);
    chk("count flag", 16'h0040, {8'h00, comm_flags});
    chk("count kept", 16'h003c, settings[0]);
    wr(CMD_FMT, 1, 24'h000011);
    rdr(CMD_FMT, 1);
    chk("ro kept", 16'hff5d, rd);
    n0 = n_clr;
    wr(CMD_CLEAR, 0, 24'h000000);
    chk("clear pulse", 16'(n0 + 1), 16'(n_clr));
    chk("cleared", 16'h0000, {8'h00, comm_flags});
    wr(8'h05, 0, 24'h000000);
    chk("nack", 16'h0000, {15'h0000, ok});
    chk("bad cmd", 16'h0080, {8'h00, comm_flags});
    wr(CMD_CLEAR, 0, 24'h000000);
    wr(CMD_KEY, 2, 24'h006b29);
    chk("key", 16'h6b29, settings[23]);
    rdr(CMD_KEY, 2);
    chk("key read", 16'hffff, rd);
    chk("key flag", 16'h0040, {8'h00, comm_flags});
    wr(CMD_CLEAR, 0, 24'h000000);
    i_pmcd_host_model.xfer(7'h16, CMD_RUN, 1, 24'h000099, 0, rd, ok);
    chk("other addr", 16'h003c, settings[0]);
    n0 = n_save;
    wr(CMD_SAVE, 0, 24'h000000);
    chk("save pulse", 16'(n0 + 1), 16'(n_save));
    n0 = n_rest;
    wr(CMD_RESTORE, 0, 24'h000000);
    chk("restore pulse", 16'(n0 + 1), 16'(n_rest));
    chk("restored", stored_defaults[2], settings[2]);
    @(posedge clk);
    #1 trim_load = 1'b1;
    trim_setpoint = 16'd1000;
    @(posedge clk);
    #1 trim_load = 1'b0;
    @(posedge clk);
    chk("trim sp", 16'd1000, settings[IX_SETPT]);
    chk("trim hi", 16'd1050, settings[IX_MHI]);
    chk("trim lo", 16'd950, settings[IX_MLO]);
    chk("trim ov", 16'd1200, settings[IX_OV]);
    chk("trim uv", 16'd800, settings[IX_UV]);
    end_of_test();
  end
endmodule : tb
